// ### rtl/irq_persist_pkg.sv
// Constants and carrier types for the persistent interrupt sources
package irq_persist_pkg;

    // Source indices into the pending-flag vector
    localparam int NUM_SRC      = 7;
    localparam int SRC_CAPTURE  = 0;
    localparam int SRC_SPI_RX   = 1;
    localparam int SRC_SPI_TX   = 2;
    localparam int SRC_UART_RX  = 3;
    localparam int SRC_UART_TX  = 4;
    localparam int SRC_ADC      = 5;
    localparam int SRC_PMP      = 6;

    // Buffer-backed sources share index with the flag vector
    localparam int NUM_CNT      = 6;
    localparam int CNT_W        = 5;

    // Buffer depths per counted source
    localparam logic [CNT_W-1:0] CNT_DEPTH [NUM_CNT] = '{
        5'h04, 5'h04, 5'h04, 5'h04, 5'h04, 5'h10
    };
    localparam logic [CNT_W-1:0] CNT_ONE   = 5'h01;
    localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;

    // Interrupt request numbers; SPI pair fixed, others arbitrary
    localparam logic [7:0] IRQ_NUM [NUM_SRC] = '{
        8'h05, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h21, 8'h22
    };
    localparam logic [7:0] IRQ_NUM_RESET = 8'h00;

    // How a counted source derives its condition
    typedef enum logic [2:0] {
        KIND_RX  = 3'h1,
        KIND_TX  = 3'h2,
        KIND_ALL = 3'h4
    } src_kind_type;

    localparam src_kind_type CNT_KIND [NUM_CNT] = '{
        KIND_RX, KIND_RX, KIND_TX, KIND_RX, KIND_TX, KIND_ALL
    };

    // One buffer's activity in a cycle
    typedef struct packed {
        logic inc;
        logic dec;
    } cnt_event_type;

    // Two-bit level-select fields
    typedef struct packed {
        logic [1:0] capture;
        logic [1:0] spi_rx;
        logic [1:0] spi_tx;
        logic [1:0] uart_rx;
        logic [1:0] uart_tx;
    } irq_level_type;

endpackage

// ### rtl/persistent_interrupt_sources.sv
// Persistent (level-held) interrupt sources with refusable flag clears
//
// Behaviour
// RULE_01: Each source keeps its request up while its cause is present.
// RULE_02: A software clear is refused while the source condition holds.
// RULE_03: SPI receive-done is request 24, SPI transfer-done is 25.
// RULE_04: Capture stays active until reads bring the count under threshold.
// RULE_05: SPI receive and transmit each have their own two-bit level field.
// RULE_06: SPI source clears only after buffer accesses pass the level.
// RULE_07: UART transmit source rises as soon as the UART is enabled.
// RULE_08: UART receive and transmit each have their own two-bit level field.
// RULE_09: UART source clears only after register accesses pass the level.
// RULE_10: ADC source holds until every stored sample has been read.
// RULE_11: Parallel port source holds until its data register is read.
// RULE_12: DMA keeps running active transfers in Idle mode.
// RULE_13: Conditions are re-evaluated every cycle, so a clear works next.
`timescale 1ns/1ns

module persistent_interrupt_sources
    import irq_persist_pkg::*;
(
    // Clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         rst,
    // Peripheral enables
    input  wire logic                         capture_enable,
    input  wire logic                         spi_enable,
    input  wire logic                         uart_enable,
    input  wire logic                         adc_enable,
    // Level-select fields
    input  wire irq_level_type                levels,
    // Buffer fill (inc) and software access (dec) strobes
    input  wire cnt_event_type [NUM_CNT-1:0]  buf_events,
    // Parallel port cause and data register read
    input  wire logic                         pmp_data_ready,
    input  wire logic                         pmp_data_read,
    // Software clear strobes, one per pending flag
    input  wire logic [NUM_SRC-1:0]           flag_clear,
    // DMA activity and power mode
    input  wire logic                         dma_active,
    input  wire logic                         idle_mode,
    // Pending flags and request summary
    output logic [NUM_SRC-1:0]                irq_pending_flag,
    output logic                              uart_irq_pending_flag,
    output logic [NUM_SRC-1:0]                clear_refused,
    output logic                              irq_any,
    output logic [7:0]                        irq_vector,
    // DMA status
    output logic                              dma_run,
    output logic                              dma_idle_run
);

    // One clock and one reset for every check in this module
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // Buffer occupancy counters

    logic [CNT_W-1:0] cnt_q [NUM_CNT];
    logic [CNT_W-1:0] cnt_d [NUM_CNT];
    logic [1:0]       lvl   [NUM_CNT];
    logic [NUM_CNT-1:0] cnt_en;
    logic [NUM_SRC-1:0] cond;

    // Map enables and level fields onto counter slots
    always_comb begin
        cnt_en[SRC_CAPTURE] = capture_enable;
        cnt_en[SRC_SPI_RX]  = spi_enable;
        cnt_en[SRC_SPI_TX]  = spi_enable;
        cnt_en[SRC_UART_RX] = uart_enable;
        cnt_en[SRC_UART_TX] = uart_enable;
        cnt_en[SRC_ADC]     = adc_enable;
        lvl[SRC_CAPTURE]    = levels.capture;     // RULE_04
        lvl[SRC_SPI_RX]     = levels.spi_rx;      // RULE_05
        lvl[SRC_SPI_TX]     = levels.spi_tx;      // RULE_05
        lvl[SRC_UART_RX]    = levels.uart_rx;     // RULE_08
        lvl[SRC_UART_TX]    = levels.uart_tx;     // RULE_08
        lvl[SRC_ADC]        = 2'h0;
    end

    for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
        // Disabled module empties its buffer; full/empty saturate
        always_comb begin
            cnt_d[i] = cnt_q[i];
            if (!cnt_en[i]) begin
                cnt_d[i] = CNT_RESET;
            end else if (buf_events[i].inc && !buf_events[i].dec
                         && cnt_q[i] != CNT_DEPTH[i]) begin
                cnt_d[i] = cnt_q[i] + CNT_ONE;
            end else if (buf_events[i].dec && !buf_events[i].inc
                         && cnt_q[i] != CNT_RESET) begin
                cnt_d[i] = cnt_q[i] - CNT_ONE;
            end
        end

        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                cnt_q[i] <= CNT_RESET;
            end else begin
                cnt_q[i] <= cnt_d[i];
            end
        end

        // Condition straight from occupancy, every cycle
        if (CNT_KIND[i] == KIND_RX) begin : g_rx
            // Held while more entries than the level remain
            assign cond[i] = cnt_en[i]
                && (cnt_q[i] > {3'h0, lvl[i]});  // RULE_04 RULE_06 RULE_09
        end else if (CNT_KIND[i] == KIND_TX) begin : g_tx
            // Empty buffer meets the level, so enable raises it at once
            assign cond[i] = cnt_en[i]
                && (cnt_q[i] <= {3'h0, lvl[i]}); // RULE_07 RULE_06 RULE_09
        end else begin : g_all
            assign cond[i] = cnt_en[i]
                && (cnt_q[i] != CNT_RESET);      // RULE_10
        end

        // One entry more than the level must raise a receive condition;
        // a level change in that cycle moves the goalposts, so skip it
        if (CNT_KIND[i] == KIND_RX) begin : g_rx_chk
            a_rx_level_rise : assert property ( // RULE_05
                (cnt_en[i] && cnt_q[i] == {3'h0, lvl[i]}
                    && buf_events[i].inc && !buf_events[i].dec)
                    |=> (cond[i] || !cnt_en[i] || !$stable(lvl[i]))
            ) else $error("rx condition not raised past level");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Parallel port cause

    logic pmp_cause_q;
    logic pmp_cause_d;

    // New data wins over a read in the same cycle
    always_comb begin
        pmp_cause_d = pmp_data_ready
            || (pmp_cause_q && !pmp_data_read);  // RULE_11
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pmp_cause_q <= 1'b0;
        end else begin
            pmp_cause_q <= pmp_cause_d;
        end
    end

    assign cond[SRC_PMP] = pmp_cause_q;

    ////////////////////////////////////////////////////////////////////////
    // Pending flags, refused clears and request number

    logic [NUM_SRC-1:0] flag_q;
    logic [NUM_SRC-1:0] flag_d;
    logic [NUM_SRC-1:0] refused_q;
    logic [NUM_SRC-1:0] refused_d;
    logic               uart_flag_q;
    logic               uart_flag_d;
    logic               any_q;
    logic               any_d;
    logic [7:0]         vec_q;
    logic [7:0]         vec_d;

    // A live condition re-sets the flag, so a clear cannot stick
    always_comb begin
        flag_d      = cond | (flag_q & ~flag_clear); // RULE_01 RULE_02 RULE_13
        refused_d   = flag_clear & cond;             // RULE_02
        uart_flag_d = flag_d[SRC_UART_RX] | flag_d[SRC_UART_TX];
        any_d       = |flag_d;
        vec_d       = IRQ_NUM_RESET;
        // Lowest index wins; scan from the top so it lands last
        for (int k = NUM_SRC - 1; k >= 0; k--) begin
            if (flag_d[k]) begin
                vec_d = IRQ_NUM[k];                  // RULE_03
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flag_q      <= '0;
            refused_q   <= '0;
            uart_flag_q <= 1'b0;
            any_q       <= 1'b0;
            vec_q       <= IRQ_NUM_RESET;
        end else begin
            flag_q      <= flag_d;
            refused_q   <= refused_d;
            uart_flag_q <= uart_flag_d;
            any_q       <= any_d;
            vec_q       <= vec_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // DMA run status; Idle mode has no say in dma_run, only in dma_idle_run

    logic dma_run_q;
    logic dma_run_d;
    logic dma_idle_q;
    logic dma_idle_d;

    // No halt-on-idle option exists, so idle only shows in status
    always_comb begin
        dma_run_d  = dma_active;                 // RULE_12
        dma_idle_d = dma_active && idle_mode;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dma_run_q  <= 1'b0;
            dma_idle_q <= 1'b0;
        end else begin
            dma_run_q  <= dma_run_d;
            dma_idle_q <= dma_idle_d;
        end
    end

    // Outputs, all from flip-flops
    assign irq_pending_flag      = flag_q;
    assign uart_irq_pending_flag = uart_flag_q;
    assign clear_refused         = refused_q;
    assign irq_any               = any_q;
    assign irq_vector            = vec_q;
    assign dma_run               = dma_run_q;
    assign dma_idle_run          = dma_idle_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_uart_rise;
        !uart_enable ##1 uart_enable;
    endsequence

    sequence s_pmp_pending;
        pmp_data_ready ##1 !pmp_data_read [*2];
    endsequence

    a_cond_holds_flag : assert property ( // RULE_01
        cond[SRC_CAPTURE] |=> flag_q[SRC_CAPTURE]
    ) else $error("capture flag dropped while cause present");

    a_clear_refused : assert property ( // RULE_02
        (flag_clear[SRC_UART_RX] && cond[SRC_UART_RX])
            |=> flag_q[SRC_UART_RX] && clear_refused[SRC_UART_RX]
    ) else $error("uart rx clear taken while cause present");

    a_spi_rx_number : assert property ( // RULE_03
        (flag_d[SRC_SPI_RX] && !flag_d[SRC_CAPTURE])
            |=> irq_any && irq_vector == 8'h18
    ) else $error("spi receive-done not request 24");

    a_spi_tx_number : assert property ( // RULE_03
        (flag_d == (7'h01 << SRC_SPI_TX)) |=> irq_vector == 8'h19
    ) else $error("spi transfer-done not request 25");

    a_vector_idle : assert property ( // RULE_03
        (flag_q == '0) |-> (irq_vector == IRQ_NUM_RESET && !irq_any)
    ) else $error("request number shown with nothing pending");

    a_capture_drain : assert property ( // RULE_04
        (capture_enable && cnt_q[SRC_CAPTURE] <= {3'h0, levels.capture}
            && flag_clear[SRC_CAPTURE]) |=> !flag_q[SRC_CAPTURE]
    ) else $error("capture flag kept after drain and clear");

    a_spi_tx_clear : assert property ( // RULE_06
        (spi_enable && cnt_q[SRC_SPI_TX] > {3'h0, levels.spi_tx}
            && flag_clear[SRC_SPI_TX]) |=> !flag_q[SRC_SPI_TX]
    ) else $error("spi tx flag kept after buffer filled");

    a_uart_tx_enable : assert property ( // RULE_07
        s_uart_rise |=> flag_q[SRC_UART_TX] && uart_irq_pending_flag
    ) else $error("uart tx not raised on enable");

    a_uart_rx_clear : assert property ( // RULE_09
        (!cond[SRC_UART_RX] && flag_clear[SRC_UART_RX]
            && !flag_clear[SRC_UART_TX] && !cond[SRC_UART_TX]
            && !flag_q[SRC_UART_TX])
            |=> !flag_q[SRC_UART_RX] && !uart_irq_pending_flag
    ) else $error("uart flag kept after level passed");

    a_adc_all_read : assert property ( // RULE_10
        (adc_enable && cnt_q[SRC_ADC] != 5'h00) |-> cond[SRC_ADC]
            ##1 (flag_q[SRC_ADC] || !adc_enable)
    ) else $error("adc source dropped with samples left");

    a_pmp_hold : assert property ( // RULE_11
        s_pmp_pending |=> flag_q[SRC_PMP]
    ) else $error("pmp source dropped without a read");

    a_dma_idle_run : assert property ( // RULE_12
        (dma_active && idle_mode) |=> dma_run && dma_idle_run
    ) else $error("dma halted in idle");

    a_clear_next : assert property ( // RULE_13
        (flag_q[SRC_PMP] && pmp_data_read && !pmp_data_ready)
            ##1 (flag_clear[SRC_PMP] && !pmp_data_ready)
            |=> !flag_q[SRC_PMP]
    ) else $error("pmp flag not cleared after read");

endmodule

// ### sim/core_flag_model.sv
// Model of the core's flag-clear software and its refusal capture
`timescale 1ns/1ns

module core_flag_model
    import irq_persist_pkg::*;
(
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst,
    // Requests from the bench
    input  wire logic [NUM_SRC-1:0] clr_mask,
    input  wire logic               clr_go,
    // Device side
    input  wire logic [NUM_SRC-1:0] clear_refused,
    output logic [NUM_SRC-1:0]      flag_clear,
    output logic [NUM_SRC-1:0]      seen,
    output logic                    done
);
    logic pend_q;

    // One-cycle clear; refusal pulse is read one edge after it lands
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flag_clear <= '0;
            seen       <= '0;
            pend_q     <= 1'b0;
            done       <= 1'b0;
        end else begin
            flag_clear <= clr_go ? clr_mask : '0;
            pend_q     <= |flag_clear;
            done       <= pend_q;
            if (pend_q) begin
                seen <= clear_refused;
            end
        end
    end
endmodule

// ### sim/test_persistent_interrupt_sources.sv
// Self-checking bench for the persistent interrupt sources
`timescale 1ns/1ns

`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin \
    n_mismatch++; $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); \
    end end

module test_persistent_interrupt_sources import irq_persist_pkg::*;;
    typedef struct packed {
        logic [2:0] src;
        logic [1:0] lvl;
        logic [2:0] n;
        logic       exp;
    } row_type;

    ////////////////////////////////////////////////////////////////////////
    // Rows: source, level, entries added, flag left after a clear
    row_type rows [12] = '{
        '{3'h0, 2'h1, 3'h2, 1'h1}, '{3'h0, 2'h1, 3'h1, 1'h0},
        '{3'h1, 2'h0, 3'h1, 1'h1}, '{3'h1, 2'h3, 3'h3, 1'h0},
        '{3'h1, 2'h3, 3'h5, 1'h1}, '{3'h2, 2'h0, 3'h1, 1'h0},
        '{3'h2, 2'h2, 3'h2, 1'h1}, '{3'h3, 2'h2, 3'h3, 1'h1},
        '{3'h4, 2'h3, 3'h4, 1'h0}, '{3'h4, 2'h0, 3'h0, 1'h1},
        '{3'h5, 2'h0, 3'h0, 1'h0}, '{3'h5, 2'h0, 3'h3, 1'h1}
    };

    logic                       clk_sys = 1'b0;
    logic                       rst     = 1'b1;
    logic [3:0]                 en      = 4'h0;
    irq_level_type              lv      = '0;
    cnt_event_type [NUM_CNT-1:0] ev     = '0;
    logic                       pmp_rdy = 1'b0;
    logic                       pmp_rd  = 1'b0;
    logic                       dma_act = 1'b0;
    logic                       idle    = 1'b0;
    logic [NUM_SRC-1:0]         clr_mask = '0;
    logic                       clr_go  = 1'b0;
    logic [NUM_SRC-1:0]         flags, refused, flag_clear, seen;
    logic                       uart_flag, any, done, drun, didle;
    logic [7:0]                 vec;
    int                         n_mismatch = 0;
    int                         check_count = 0;
    row_type                    r;

    // 250 MHz system clock
    always #2 clk_sys = ~clk_sys;

    persistent_interrupt_sources i_dut (
        .clk_sys(clk_sys), .rst(rst), .capture_enable(en[0]),
        .spi_enable(en[1]), .uart_enable(en[2]), .adc_enable(en[3]),
        .levels(lv), .buf_events(ev), .pmp_data_ready(pmp_rdy),
        .pmp_data_read(pmp_rd), .flag_clear(flag_clear),
        .dma_active(dma_act), .idle_mode(idle),
        .irq_pending_flag(flags), .uart_irq_pending_flag(uart_flag),
        .clear_refused(refused), .irq_any(any), .irq_vector(vec),
        .dma_run(drun), .dma_idle_run(didle)
    );

    core_flag_model i_core (
        .clk_sys(clk_sys), .rst(rst), .clr_mask(clr_mask), .clr_go(clr_go),
        .clear_refused(refused), .flag_clear(flag_clear), .seen(seen),
        .done(done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Closing verdict, shared by the main sequence and the watchdogs
    task automatic report_and_stop();
        $display("TB: checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Inputs always move 1 ns after the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Strobe inc or dec of one slot, n times back to back
    task automatic pulse(input int s, input int n, input bit dec);
        repeat (n) begin
            if (dec) ev[s].dec = 1'b1;
            else ev[s].inc = 1'b1;
            step(1);
            ev[s] = '0;
        end
    endtask

    // Ask the core model for a clear and wait, bounded, for its verdict
    task automatic sw_clear(input logic [NUM_SRC-1:0] m);
        int k;
        clr_mask = m;
        clr_go = 1'b1;
        step(1);
        clr_go = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 8) begin
            step(1);
            k++;
        end
        if (k == 8) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask

    // Whole-run watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        en = 4'h4;
        step(16);
        `CHK("flags in reset", 7'h00, flags)
        rst = 1'b0;
        for (int i = 0; i < 12; i++) begin
            r = rows[i];
            en = 4'h0;
            step(2);
            sw_clear(7'h7f);
            en = 4'h1 << ((r.src + 3'h1) >> 1);
            lv = irq_level_type'({5{r.lvl}});
            pulse(r.src, r.n, 1'b0);
            step(2);
            sw_clear(7'h01 << r.src);
            `CHK("row flag", r.exp, flags[r.src])
            `CHK("row refused", r.exp, seen[r.src])
        end
        // Transmit flag on enable, then a clear one cycle after it goes false
        en = 4'h0;
        lv = '0;
        step(2);
        sw_clear(7'h7f);
        en = 4'h4;
        step(1);
        `CHK("uart tx flag", 1'b1, flags[4])
        `CHK("uart flag", 1'b1, uart_flag)
        `CHK("uart tx vector", 8'h1b, vec)
        pulse(4, 1, 1'b0);
        sw_clear(7'h10);
        `CHK("uart tx cleared", 1'b0, flags[4])
        // Receive flag refused until the register is read
        pulse(3, 1, 1'b0);
        step(1);
        sw_clear(7'h08);
        `CHK("uart rx held", 1'b1, flags[3])
        pulse(3, 1, 1'b1);
        sw_clear(7'h08);
        `CHK("uart rx cleared", 1'b0, flags[3])
        `CHK("uart flag low", 1'b0, uart_flag)
        // SPI request numbers
        en = 4'h2;
        step(1);
        `CHK("spi tx vector", 8'h19, vec)
        pulse(1, 1, 1'b0);
        step(1);
        `CHK("spi rx vector", 8'h18, vec)
        `CHK("any pending", 1'b1, any)
        // Parallel port cause holds until its data register is read
        en = 4'h0;
        step(1);
        sw_clear(7'h7f);
        pmp_rdy = 1'b1;
        step(1);
        pmp_rdy = 1'b0;
        step(1);
        `CHK("pmp flag", 1'b1, flags[6])
        `CHK("pmp vector", 8'h22, vec)
        sw_clear(7'h40);
        `CHK("pmp held", 1'b1, flags[6])
        // Read, then the clear one edge later, as soon as the cause falls
        pmp_rd = 1'b1;
        sw_clear(7'h40);
        pmp_rd = 1'b0;
        `CHK("pmp cleared", 1'b0, flags[6])
        `CHK("none pending", 1'b0, any)
        `CHK("idle vector", 8'h00, vec)
        // DMA keeps running in Idle; status follows one edge late
        `CHK("dma stopped", 1'b0, drun)
        dma_act = 1'b1;
        step(2);
        `CHK("dma run", 1'b1, drun)
        `CHK("dma not idle", 1'b0, didle)
        idle = 1'b1;
        step(4);
        `CHK("dma idle keeps run", 1'b1, drun)
        `CHK("dma idle run", 1'b1, didle)
        // Reset in mid-run, then enable shows again at once
        en = 4'h4;
        rst = 1'b1;
        step(1);
        `CHK("flags mid reset", 7'h00, flags)
        `CHK("dma mid reset", 1'b0, drun)
        rst = 1'b0;
        step(1);
        `CHK("tx after reset", 1'b1, flags[4])
        report_and_stop();
    end
endmodule
